//--- src/clock_mode_consts.svh
// constants of the clock source and operating mode controller
`ifndef CLOCK_MODE_CONSTS_SVH
`define CLOCK_MODE_CONSTS_SVH

// ----------------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------------
`define ADDR_SYSTEM_MODE 8'h00
`define ADDR_WATCHDOG_CTRL 8'h01
`define ADDR_LVD_CTRL 8'h02
`define ADDR_STATUS 8'h03

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SYSTEM_MODE_POR 8'h03
`define WATCHDOG_CTRL_POR 8'h02
`define LVD_CTRL_POR 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FLD_DIV_HI 7
`define FLD_DIV_LO 5
`define FLD_FAST_READY 2
`define FLD_SLOW_READY 3
`define FLD_IDLE_SELECT 1
`define FLD_FAST_SLOW 0
`define FLD_KEEP_ON 0
`define FLD_WDT_ENABLE 1
`define FLD_LVD_ENABLE 0

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define WAKE_SUB_EDGES 8'h10

`endif

//--- src/clock_mode_pkg.sv
// types of the clock source and operating mode controller
package clock_mode_pkg;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_SLOW,
    ST_IDLE_CLOCK_OFF_MODE,
    ST_IDLE_CLOCK_ON_MODE,
    ST_DEEP_SLEEP_MODE,
    ST_SLEEP_KEEP_SUB_MODE,
    ST_WAKE
  } op_mode_t;

  // configuration options, static straps
  typedef struct packed {
    logic [1:0] fast_src; // 0 fast crystal, 1 external rc, 2/3 fast internal rc
    logic slow_src;       // 0 slow crystal, 1 slow internal rc
    logic sub_src;        // same encoding as slow_src
    logic tbc_src;        // same encoding as slow_src
    logic wdt_src;        // 0 substitute clock, 1 system clock / 4
  } cfg_t;

  typedef struct packed {
    logic cpu_clock;
    logic sys_clock;
    logic substitute_clock;
    logic timebase_clock;
    logic watchdog_clock;
    logic watchdog_disable;
    logic fast_osc_en;
    logic slow_osc_en;
  } clocks_t;

endpackage : clock_mode_pkg

//--- src/clock_mode_ctrl.sv
// clock source selection, dividers and operating mode sequencer
`timescale 1ns/1ps
`include "clock_mode_consts.svh"

// How it works
// - system clock picked by fast/slow bit and divider
// - fast clock divided by one to sixty-four
// - fast clock from one of three oscillators
// - slow clock from slow crystal or rc
// - substitute and timebase clocks from slow sources
// - cpu runs on substitute clock after wake, except from idle clock-on
// - watchdog clock from substitute or sysclk/4
// - timebase clock drives timebase and timers
// - six modes, two run, four stop cpu
// - slow mode runs slow, fast osc off
// - halt with idle select low sleeps
// - deep sleep stops cpu, sub, watchdog
// - low voltage enable blocks deep sleep
// - keep-sub sleep keeps sub when needed
// - idle clock-off stops system oscillator
// - idle clock-off watchdog follows its source
// - idle clock-on keeps system oscillator running
// - idle clock-on keeps watchdog clock running
// - switching to slow stops fast oscillator
// - divider codes map slow and fast ratios
module clock_mode_ctrl (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // oscillator outputs, asynchronous
  input wire logic fast_crystal_osc,
  input wire logic external_rc_osc,
  input wire logic fast_internal_rc_osc,
  input wire logic slow_crystal_osc,
  input wire logic slow_internal_rc_osc,
  // configuration options
  input wire clock_mode_pkg::cfg_t cfg,
  // cpu side
  input wire logic halt_req,
  input wire logic wake_req,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [7:0] rdata,
  // generated clocks and status
  output clock_mode_pkg::clocks_t clocks,
  output clock_mode_pkg::op_mode_t mode
);
  import clock_mode_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic fast_prev;
    logic sys_prev;
    logic sub_prev;
    logic [5:0] div_cnt;
    logic [1:0] sys4_cnt;
    logic [7:0] system_mode_reg;
    logic [7:0] watchdog_control_reg;
    logic [7:0] lvd_reg;
    cfg_t cfg_q;
    logic cfg_loaded;
    op_mode_t state;
    logic resume_slow;
    logic [7:0] wake_cnt;
    logic [7:0] rdata;
    clocks_t clocks;
  } core_t;

  core_t cur_reg;
  core_t cur_next;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic div_tap(input logic [5:0] cnt, input logic [2:0] sel);
    logic tap;
    tap = 1'b0;
    case (sel)
      3'h2: tap = cnt[5];
      3'h3: tap = cnt[4];
      3'h4: tap = cnt[3];
      3'h5: tap = cnt[2];
      3'h6: tap = cnt[1];
      3'h7: tap = cnt[0];
      default: tap = 1'b0;
    endcase
    return tap;
  endfunction : div_tap

  function automatic logic slow_pick(input logic src, input logic [4:0] osc);
    return src ? osc[0] : osc[1];
  endfunction : slow_pick

  // divider codes 000 and 001 select the slow clock while the fast/slow bit is low
  function automatic logic wants_slow(input logic [7:0] system_mode_register);
    return !system_mode_register[`FLD_FAST_SLOW] && (system_mode_register[`FLD_DIV_HI:`FLD_DIV_LO] < 3'h2);
  endfunction : wants_slow

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic [4:0] osc;
  logic fast_raw;
  logic fast_lvl;
  logic slow_lvl;
  logic sub_lvl;
  logic tbc_lvl;
  logic sys_lvl;
  logic sys4_lvl;
  logic fast_on;
  logic sys_on;
  logic sub_on;
  logic tbc_on;
  logic wdt_on;
  logic cpu_on;
  logic wdt_en;
  logic lvd_en;
  logic keep_sub;
  logic target_slow;
  logic run_slow_now;
  logic sub_rise;
  logic wdt_lvl;

  always_comb begin
    cur_next = cur_reg;
    osc = cur_reg.sync2;
    wdt_en = cur_reg.watchdog_control_reg[`FLD_WDT_ENABLE];
    lvd_en = cur_reg.lvd_reg[`FLD_LVD_ENABLE];
    run_slow_now = wants_slow(cur_reg.system_mode_reg);
    target_slow = cur_reg.resume_slow;

    // ----------------------------------------------------------------------
    // synchronisers and straps
    // ----------------------------------------------------------------------
    // first stage is read only by the second
    cur_next.sync1 = {fast_crystal_osc, external_rc_osc, fast_internal_rc_osc,
                      slow_crystal_osc, slow_internal_rc_osc};
    cur_next.sync2 = cur_reg.sync1;

    // straps caught once after reset release
    if (!cur_reg.cfg_loaded) begin
      cur_next.cfg_q = cfg;
      cur_next.cfg_loaded = 1'b1;
    end

    // ----------------------------------------------------------------------
    // oscillator gating per mode
    // ----------------------------------------------------------------------
    fast_on = 1'b0;
    sys_on = 1'b0;
    cpu_on = 1'b0;
    sub_on = 1'b1;
    tbc_on = 1'b1;
    case (cur_reg.state)
      ST_NORMAL: begin
        fast_on = 1'b1;
        sys_on = 1'b1;
        cpu_on = 1'b1;
      end
      ST_SLOW: begin
        fast_on = 1'b0;
        sys_on = 1'b1;
        cpu_on = 1'b1;
      end
      ST_IDLE_CLOCK_OFF_MODE: begin
        sys_on = 1'b0;
      end
      ST_IDLE_CLOCK_ON_MODE: begin
        fast_on = !cur_reg.resume_slow;
        sys_on = 1'b1;
      end
      ST_DEEP_SLEEP_MODE: begin
        sub_on = 1'b0;
        tbc_on = 1'b0;
      end
      ST_SLEEP_KEEP_SUB_MODE: begin
        tbc_on = 1'b0;
      end
      ST_WAKE: begin
        // fast oscillator restarts, unless resuming slow mode, while the cpu borrows the substitute clock
        fast_on = !target_slow;
        cpu_on = 1'b1;
      end
      default: begin
        sys_on = 1'b0;
      end
    endcase

    keep_sub = lvd_en || (wdt_en && !cur_reg.cfg_q.wdt_src);
    if (cur_reg.state == ST_SLEEP_KEEP_SUB_MODE) begin
      sub_on = keep_sub;
    end

    // ----------------------------------------------------------------------
    // watchdog clock gating
    // ----------------------------------------------------------------------
    wdt_on = 1'b1;
    case (cur_reg.state)
      ST_IDLE_CLOCK_OFF_MODE: wdt_on = !cur_reg.cfg_q.wdt_src;
      ST_IDLE_CLOCK_ON_MODE: wdt_on = 1'b1;
      ST_DEEP_SLEEP_MODE: wdt_on = 1'b0;
      ST_SLEEP_KEEP_SUB_MODE: wdt_on = keep_sub;
      default: wdt_on = 1'b1;
    endcase

    // ----------------------------------------------------------------------
    // source selection
    // ----------------------------------------------------------------------
    case (cur_reg.cfg_q.fast_src)
      2'h0: fast_raw = osc[4];
      2'h1: fast_raw = osc[3];
      default: fast_raw = osc[2];
    endcase
    fast_lvl = fast_on & fast_raw;
    slow_lvl = slow_pick(cur_reg.cfg_q.slow_src, osc);
    sub_lvl = slow_pick(cur_reg.cfg_q.sub_src, osc) & sub_on;
    tbc_lvl = slow_pick(cur_reg.cfg_q.tbc_src, osc) & tbc_on;

    // ----------------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------------
    // fast divider advances only while the fast clock runs
    if (fast_lvl && !cur_reg.fast_prev) begin
      cur_next.div_cnt = cur_reg.div_cnt + 6'h01;
    end
    cur_next.fast_prev = fast_lvl;

    if (cur_reg.system_mode_reg[`FLD_FAST_SLOW]) begin
      sys_lvl = fast_lvl;
    end else if (run_slow_now) begin
      sys_lvl = slow_lvl;
    end else begin
      sys_lvl = div_tap(cur_reg.div_cnt, cur_reg.system_mode_reg[`FLD_DIV_HI:`FLD_DIV_LO]);
    end
    if (cur_reg.state == ST_IDLE_CLOCK_ON_MODE && cur_reg.resume_slow) begin
      sys_lvl = slow_lvl;
    end
    sys_lvl = sys_lvl & sys_on;

    // quarter-rate tap follows the gated system clock, so it stops with it
    if (sys_lvl && !cur_reg.sys_prev) begin
      cur_next.sys4_cnt = cur_reg.sys4_cnt + 2'h1;
    end
    cur_next.sys_prev = sys_lvl;
    sys4_lvl = cur_reg.sys4_cnt[1];

    sub_rise = sub_lvl && !cur_reg.sub_prev;
    cur_next.sub_prev = sub_lvl;

    // ----------------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------------
    case (cur_reg.state)
      ST_NORMAL, ST_SLOW: begin
        cur_next.state = run_slow_now ? ST_SLOW : ST_NORMAL;
        if (halt_req) begin
          cur_next.resume_slow = run_slow_now;
          if (cur_reg.system_mode_reg[`FLD_IDLE_SELECT]) begin
            if (cur_reg.watchdog_control_reg[`FLD_KEEP_ON]) begin
              cur_next.state = ST_IDLE_CLOCK_ON_MODE;
            end else begin
              cur_next.state = ST_IDLE_CLOCK_OFF_MODE;
            end
          end else if (lvd_en) begin
            cur_next.state = ST_SLEEP_KEEP_SUB_MODE;
          end else begin
            cur_next.state = ST_DEEP_SLEEP_MODE;
          end
        end
      end
      ST_IDLE_CLOCK_ON_MODE: begin
        if (wake_req) begin
          cur_next.state = cur_reg.resume_slow ? ST_SLOW : ST_NORMAL;
        end
      end
      ST_IDLE_CLOCK_OFF_MODE, ST_DEEP_SLEEP_MODE, ST_SLEEP_KEEP_SUB_MODE: begin
        if (wake_req) begin
          cur_next.state = ST_WAKE;
          cur_next.wake_cnt = 8'h00;
        end
      end
      ST_WAKE: begin
        if (sub_rise) begin
          cur_next.wake_cnt = cur_reg.wake_cnt + 8'h01;
        end
        if (cur_reg.wake_cnt >= `WAKE_SUB_EDGES) begin
          cur_next.state = target_slow ? ST_SLOW : ST_NORMAL;
        end
      end
      default: begin
        cur_next.state = ST_NORMAL;
      end
    endcase

    // ----------------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------------
    if (we) begin
      if (addr == `ADDR_SYSTEM_MODE) begin
        cur_next.system_mode_reg = {wdata[7:4], 2'h0, wdata[1:0]};
      end else if (addr == `ADDR_WATCHDOG_CTRL) begin
        cur_next.watchdog_control_reg = {6'h00, wdata[1:0]};
      end else if (addr == `ADDR_LVD_CTRL) begin
        cur_next.lvd_reg = {7'h00, wdata[0]};
      end
    end

    // ----------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------------------------------------
    cur_next.rdata = 8'h00;
    if (re) begin
      if (addr == `ADDR_SYSTEM_MODE) begin
        cur_next.rdata = cur_reg.system_mode_reg;
        cur_next.rdata[`FLD_FAST_READY] = cur_reg.clocks.fast_osc_en;
        cur_next.rdata[`FLD_SLOW_READY] = cur_reg.cfg_loaded;
      end else if (addr == `ADDR_WATCHDOG_CTRL) begin
        cur_next.rdata = cur_reg.watchdog_control_reg;
      end else if (addr == `ADDR_LVD_CTRL) begin
        cur_next.rdata = cur_reg.lvd_reg;
      end else if (addr == `ADDR_STATUS) begin
        cur_next.rdata = {3'h0, cur_reg.clocks.cpu_clock, cur_reg.clocks.fast_osc_en, cur_reg.state};
      end
    end

    // ----------------------------------------------------------------------
    // registered clock outputs
    // ----------------------------------------------------------------------
    // the system clock is stopped in keep-sub sleep, so the watchdog leans on the substitute clock there
    wdt_lvl = cur_reg.cfg_q.wdt_src ? sys4_lvl : sub_lvl;
    if (cur_reg.state == ST_SLEEP_KEEP_SUB_MODE) begin
      wdt_lvl = sub_lvl;
    end
    cur_next.clocks.cpu_clock = cpu_on & ((cur_reg.state == ST_WAKE) ? sub_lvl : sys_lvl);
    cur_next.clocks.sys_clock = sys_lvl;
    cur_next.clocks.substitute_clock = sub_lvl;
    cur_next.clocks.timebase_clock = tbc_lvl;
    cur_next.clocks.watchdog_clock = wdt_on & wdt_lvl;
    cur_next.clocks.watchdog_disable = (cur_reg.state == ST_DEEP_SLEEP_MODE);
    cur_next.clocks.fast_osc_en = fast_on;
    cur_next.clocks.slow_osc_en = sub_on | tbc_on | run_slow_now;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_reg <= '0;
      cur_reg.system_mode_reg <= `SYSTEM_MODE_POR;
      cur_reg.watchdog_control_reg <= `WATCHDOG_CTRL_POR;
      cur_reg.lvd_reg <= `LVD_CTRL_POR;
      cur_reg.state <= ST_NORMAL;
    end else if (ce) begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------------------------------------
  assign rdata = cur_reg.rdata;
  assign clocks = cur_reg.clocks;
  assign mode = cur_reg.state;

endmodule : clock_mode_ctrl

//--- dv/clock_mode_assertions.sv
// assertions on the ports of the clock and mode controller
`timescale 1ns/1ps
module clock_mode_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs watched
  input wire logic ce,
  input wire clock_mode_pkg::cfg_t cfg,
  input wire logic halt_req,
  input wire logic wake_req,
  // outputs watched
  input wire clock_mode_pkg::clocks_t clocks,
  input wire clock_mode_pkg::op_mode_t mode
);
  import clock_mode_pkg::*;
  logic stopped;
  logic running;
  assign stopped = mode inside {ST_IDLE_CLOCK_OFF_MODE, ST_IDLE_CLOCK_ON_MODE, ST_DEEP_SLEEP_MODE, ST_SLEEP_KEEP_SUB_MODE};
  assign running = mode inside {ST_NORMAL, ST_SLOW};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // --------
  // mode sequencing
  // --------
  halt_enters_stop_a: assert property (ce && halt_req && running |=> stopped)
    else $error("halt did not stop the cpu");
  wake_to_sub_a: assert property (ce && wake_req && stopped && mode != ST_IDLE_CLOCK_ON_MODE |=> mode == ST_WAKE)
    else $error("wake did not pass through substitute clocking");
  idle_clock_on_mode_resume_a: assert property (ce && wake_req && mode == ST_IDLE_CLOCK_ON_MODE |=> running)
    else $error("wake from idle with clock on did not resume");
  wake_bounded_a: assert property ($rose(mode == ST_WAKE) |-> ##[1:1000] running)
    else $error("substitute clocking after wake did not end");
  // --------
  // clock gating per mode
  // --------
  cpu_gated_a: assert property (stopped [*3] |-> !clocks.cpu_clock)
    else $error("cpu clock runs in a stop mode");
  deep_sleep_off_a: assert property ((mode == ST_DEEP_SLEEP_MODE) [*3] |-> clocks.watchdog_disable
    && !clocks.substitute_clock && !clocks.watchdog_clock)
    else $error("deep sleep left a clock or the watchdog on");
  slow_fast_off_a: assert property ((mode == ST_SLOW) [*4] |-> !clocks.fast_osc_en)
    else $error("fast oscillator on in slow mode");
  idle_clock_off_mode_off_a: assert property ((mode == ST_IDLE_CLOCK_OFF_MODE) [*4] ##0 cfg.wdt_src |-> !clocks.sys_clock
    && !clocks.watchdog_clock)
    else $error("idle with clock off left system or watchdog clock on");
  cover property (mode == ST_DEEP_SLEEP_MODE ##1 mode == ST_WAKE);
  cover property (mode == ST_IDLE_CLOCK_ON_MODE ##1 mode == ST_SLOW);
  cover property (mode == ST_SLEEP_KEEP_SUB_MODE [*8]);
endmodule : clock_mode_assertions

//--- dv/periph_model.sv
// behavioural peripherals that count the edges of every handed-out clock
`timescale 1ns/1ps
module periph_model (
  // clock, reset and counter clear
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  // clocks from the controller
  input wire clock_mode_pkg::clocks_t clocks,
  // rises of cpu, system, substitute, watchdog, timebase
  output logic [4:0][15:0] ticks
);
  import clock_mode_pkg::*;
  logic [4:0] now;
  logic [4:0] last_reg;
  assign now = {clocks.timebase_clock, clocks.watchdog_clock, clocks.substitute_clock, clocks.sys_clock,
    clocks.cpu_clock};
  always_ff @(posedge clk) begin
    last_reg <= now;
    for (int i = 0; i < 5; i++) begin
      if (!rst_n || clr) begin
        ticks[i] <= 16'h0;
      end else if (now[i] && !last_reg[i]) begin
        ticks[i] <= ticks[i] + 16'h1;
      end
    end
  end
endmodule : periph_model

//--- dv/tb_clock_source_and_power_mode_control.sv
// self-checking bench of the clock source and operating mode controller
`timescale 1ns/1ps
`include "clock_mode_consts.svh"
module tb_clock_source_and_power_mode_control;
  import clock_mode_pkg::*;
  logic clk, rst_n, ce, fosc, sosc, halt_req, wake_req, we, re, re_d, clr;
  logic [7:0] addr, wdata, rdata;
  cfg_t cfg;
  clocks_t clocks;
  op_mode_t mode;
  logic [4:0][15:0] ticks;
  logic [15:0] exp_q [$];
  int n_errors, cmp_count;
  clock_mode_ctrl i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .fast_crystal_osc(fosc), .external_rc_osc(fosc),
    .fast_internal_rc_osc(fosc), .slow_crystal_osc(sosc), .slow_internal_rc_osc(sosc), .cfg(cfg),
    .halt_req(halt_req), .wake_req(wake_req), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
    .clocks(clocks), .mode(mode));
  periph_model i_periph (.clk(clk), .rst_n(rst_n), .clr(clr), .clocks(clocks), .ticks(ticks));
  // --------
  // shared tasks
  // --------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // mask in the upper byte, masked expectation in the lower
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e & m});
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
  endtask : rd
  task automatic pulse(input bit w);
    @(posedge clk);
    if (w) wake_req <= 1'b1;
    else halt_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    halt_req <= 1'b0;
  endtask : pulse
  // settle, clear the edge counters, then let n cycles pass
  task automatic span(input int n);
    repeat (16) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : span
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) re_d <= re;
  always @(negedge clk) begin
    logic [15:0] e;
    if (re_d) begin
      e = exp_q.pop_front();
      chk(rdata & e[15:8], e[7:0], "rdata");
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // oscillators at four and sixteen cycles, edges away from the sampling edge
  initial begin
    fosc = 1'b0;
    forever #20 fosc = ~fosc;
  end
  initial begin
    sosc = 1'b0;
    forever #80 sosc = ~sosc;
  end
  initial begin
    #600000;
    n_errors++;
    complete_run();
  end
  // --------
  // main sequence
  // --------
  initial begin
    logic [31:0] r;
    logic w;
    int n, k;
    logic [7:0] hsm [5] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h02};
    logic kon [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic lvd [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    op_mode_t hmode [5] = '{ST_DEEP_SLEEP_MODE, ST_SLEEP_KEEP_SUB_MODE, ST_IDLE_CLOCK_OFF_MODE, ST_IDLE_CLOCK_ON_MODE, ST_IDLE_CLOCK_ON_MODE};
    op_mode_t hback [5] = '{ST_NORMAL, ST_NORMAL, ST_NORMAL, ST_NORMAL, ST_SLOW};
    {rst_n, halt_req, wake_req, we, re, clr, addr, wdata} = '0;
    ce = 1'b1;
    cfg = '{fast_src: 2'h2, slow_src: 1'b1, sub_src: 1'b1, tbc_src: 1'b1, wdt_src: 1'b1};
    void'($urandom(32'ha8cd2ff3));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADDR_SYSTEM_MODE, 8'hf3, `SYSTEM_MODE_POR);
    rd(`ADDR_WATCHDOG_CTRL, 8'hff, `WATCHDOG_CTRL_POR);
    rd(`ADDR_LVD_CTRL, 8'hff, `LVD_CTRL_POR);
    rd(`ADDR_STATUS, 8'h07, 8'(ST_NORMAL));
    rd(8'h7f, 8'hff, 8'h00);
    r = $urandom;
    wr(`ADDR_SYSTEM_MODE, r[7:0]);
    rd(`ADDR_SYSTEM_MODE, 8'hf3, r[7:0]);
    // divider codes 0..7 with the fast/slow bit low, then the undivided fast clock
    for (int c = 0; c < 9; c++) begin
      wr(`ADDR_SYSTEM_MODE, (c == 8) ? 8'h01 : {c[2:0], 5'h00});
      span(512);
      n = (c == 8) ? 128 : (c < 2) ? 32 : 512 >> (10 - c);
      chk({7'h0, ticks[0] + 16'h1 - n[15:0] <= 16'h2}, 8'h01, "cpu_rate");
      rd(`ADDR_STATUS, 8'h0f, (c < 2) ? 8'(ST_SLOW) : {4'h0, 1'b1, 3'(ST_NORMAL)});
    end
    // every stop mode entered by halt, a second halt ignored, then woken;
    // the second pass restarts with the watchdog on the substitute clock
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        rst_n <= 1'b0;
        cfg <= '{fast_src: 2'h0, slow_src: 1'b0, sub_src: 1'b1, tbc_src: 1'b1, wdt_src: 1'b0};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`ADDR_STATUS, 8'h07, 8'(ST_NORMAL));
      end
      for (int i = 0; i < 5; i++) begin
        wr(`ADDR_SYSTEM_MODE, hsm[i]);
        wr(`ADDR_WATCHDOG_CTRL, {7'h0, kon[i]});
        wr(`ADDR_LVD_CTRL, {7'h0, lvd[i]});
        repeat (8) @(posedge clk);
        pulse(1'b0);
        pulse(1'b0);
        rd(`ADDR_STATUS, 8'h07, 8'(hmode[i]));
        span(200);
        chk(ticks[0][7:0], 8'h00, "cpu_ticks");
        w = hmode[i] inside {ST_SLEEP_KEEP_SUB_MODE, ST_IDLE_CLOCK_ON_MODE} || (!cfg.wdt_src && hmode[i] == ST_IDLE_CLOCK_OFF_MODE);
        chk({4'h0, ticks[4] != 0, ticks[3] != 0, ticks[2] != 0, ticks[1] != 0}, {4'h0, hmode[i] inside {ST_IDLE_CLOCK_OFF_MODE,
          ST_IDLE_CLOCK_ON_MODE}, w, hmode[i] != ST_DEEP_SLEEP_MODE, hmode[i] == ST_IDLE_CLOCK_ON_MODE}, "gated_clocks");
        chk({7'h0, clocks.slow_osc_en}, {7'h0, hmode[i] != ST_DEEP_SLEEP_MODE}, "slow_osc_en");
        pulse(1'b1);
        k = 0;
        while (!(mode inside {ST_NORMAL, ST_SLOW}) && k < 1000) begin
          @(posedge clk);
          k++;
        end
        chk({7'h0, k < 1000}, 8'h01, "wake_time");
        rd(`ADDR_STATUS, 8'h07, 8'(hback[i]));
      end
    end
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : tb_clock_source_and_power_mode_control
bind clock_mode_ctrl clock_mode_assertions i_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .cfg(cfg),
  .halt_req(halt_req), .wake_req(wake_req), .clocks(clocks), .mode(mode));
